// ==== hw/ttc_pkg.sv ====
// Package: constants and carrier types for the thermometer/thermostat core
package ttc_pkg;

  // ==========================================================
  // Widths
  localparam int unsigned TEMP_W = 9;
  localparam int unsigned BIT_CNT_W = 4;
  localparam int unsigned GATE_W = 8;
  localparam int unsigned TMO_W = 28;

  // ==========================================================
  // Temperature codes, half a degree per step
  localparam logic [8:0] TEMP_MIN = 9'h192;
  localparam logic [8:0] TEMP_MAX = 9'h0FA;
  localparam logic [8:0] TEMP_STEP = 9'h001;

  // ==========================================================
  // Measurement engine presets (plain defaults)
  localparam logic [8:0] BASE_COUNT = 9'h0C8;
  localparam logic [8:0] SLOPE_BASE = 9'h040;
  localparam logic [8:0] SLOPE_STEP = 9'h001;
  localparam logic [8:0] CNT_LAST = 9'h001;
  localparam logic [7:0] GATE_LEN = 8'hC8;
  localparam logic [7:0] GATE_ONE = 8'h01;

  // ==========================================================
  // Conversion time limit
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned CONVERT_PIN_MAX_NS = 1000000000;
  localparam int unsigned CONVERT_PIN_MAX_CYC = CONVERT_PIN_MAX_NS / CLK_PERIOD_NS;
  localparam logic [27:0] TMO_ONE = 28'h0000001;

  // ==========================================================
  // Serial opcodes and bit counts
  localparam logic [7:0] OP_RD_TEMP = 8'hAA;
  localparam logic [7:0] OP_RD_COUNT = 8'hA0;
  localparam logic [7:0] OP_RD_SLOPE = 8'hA9;
  localparam logic [7:0] OP_WR_HIGH = 8'h01;
  localparam logic [7:0] OP_WR_LOW = 8'h02;
  localparam logic [3:0] CMD_BIT_LAST = 4'h7;
  localparam logic [3:0] DATA_BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_ONE = 4'h1;

  // ==========================================================
  // Limit storage slots
  localparam int unsigned LIM_SLOTS = 2;
  localparam logic LIM_SEL_HIGH = 1'b0;
  localparam logic LIM_SEL_LOW = 1'b1;
  localparam logic [8:0] LIM_HIGH_INIT = 9'h0FA;
  localparam logic [8:0] LIM_LOW_INIT = 9'h192;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic sel;
    logic sclk;
    logic dq;
    logic ref_osc;
    logic gate_osc;
  } ttc_pins_t;

  typedef struct packed {
    logic high;
    logic low;
    logic com;
  } ttc_trip_t;

  typedef enum logic [1:0] {
    SP_CMD,
    SP_OUT,
    SP_IN,
    SP_DONE
  } ttc_sp_state_t;

  typedef enum logic {
    CV_IDLE,
    CV_RUN
  } ttc_cv_state_t;

endpackage

// ==== hw/ttc_sync.sv ====
// Two-stage synchroniser for the pin inputs of the core
`timescale 1ns/1ps
`default_nettype none

module ttc_sync (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire ttc_pkg::ttc_pins_t i_async,
  output ttc_pkg::ttc_pins_t o_sync
);

  ttc_pkg::ttc_pins_t meta_reg;
  ttc_pkg::ttc_pins_t meta_next;
  ttc_pkg::ttc_pins_t sync_reg;
  ttc_pkg::ttc_pins_t sync_next;

  // ==========================================================
  // First stage feeds only the second stage
  always_comb begin
    meta_next = i_ce ? i_async : meta_reg;
    sync_next = i_ce ? meta_reg : sync_reg;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign o_sync = sync_reg;

endmodule

`default_nettype wire

// ==== hw/ttc_lim_mem.sv ====
// Retained storage for the high and low limits, registered read
`timescale 1ns/1ps
`default_nettype none

module ttc_lim_mem (
  input wire logic i_clk,
  input wire logic i_ce,
  input wire logic i_we,
  input wire logic i_wsel,
  input wire logic [8:0] i_wdata,
  output logic [8:0] o_high,
  output logic [8:0] o_low
);

  logic [8:0] cell_q [ttc_pkg::LIM_SLOTS];
  logic [8:0] high_reg;
  logic [8:0] low_reg;

  // ==========================================================
  // Cells ignore reset so settings survive it, like NV cells
  for (genvar g = 0; g < ttc_pkg::LIM_SLOTS; g++) begin : g_cell
    logic [8:0] cell_reg = (g == 0) ? ttc_pkg::LIM_HIGH_INIT : ttc_pkg::LIM_LOW_INIT;
    logic [8:0] cell_next;
    always_comb begin
      cell_next = cell_reg;
      if (i_ce && i_we && (i_wsel == 1'(g))) begin
        cell_next = i_wdata;
      end
    end
    always_ff @(posedge i_clk) begin
      cell_reg <= cell_next;
    end
    assign cell_q[g] = cell_reg;
  end

  // Read data from a register, one cycle behind the cells
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      high_reg <= cell_q[ttc_pkg::LIM_SEL_HIGH];
      low_reg <= cell_q[ttc_pkg::LIM_SEL_LOW];
    end
  end

  assign o_high = high_reg;
  assign o_low = low_reg;

endmodule

`default_nettype wire

// ==== hw/ttc_core.sv ====
// Top of the thermometer/thermostat core: measurement, serial port, trips
//
// Operation
// - Each measurement loads counter with minus-55 base and presets temperature to minus 55.
// - Counter empty inside gate: step temperature, reload from slope accumulator, repeat.
// - Temperature held as 9-bit two's complement, half a degree per step.
// - Codes: +125 is 0FAh, minus half is 1FFh, minus 55 is 192h.
// - Result stays within minus 55 to plus 125 degrees.
// - Serial words travel least significant bit first, both directions.
// - Extra clocks after the top bit shift out zeros.
// - Read counter returns count left when the last gate closed.
// - Read slope copies slope accumulator into count register.
// - Stand-alone: falling edge on convert pin starts a conversion.
// - Combined trip rises above high limit, falls below low limit.
// - High trip is set while temperature is at or above high limit.
// - Low trip is set while temperature is at or below low limit.
// - Limits kept in retained storage across reset.
// - Each conversion finishes within one second of its start.
// - Opcodes AAh, A0h, A9h read nine bits after the opcode.
// - Opcodes 01h and 02h write high and low limits, nine bits.
`timescale 1ns/1ps
`default_nettype none

module ttc_core #(
  parameter int unsigned CONVERT_PIN_MAX_CYC = ttc_pkg::CONVERT_PIN_MAX_CYC
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_CE,
  input wire logic I_PORT_SEL,
  input wire logic I_SHIFT_CLOCK_OR_CONVERT_PIN,
  input wire logic I_DQ,
  input wire logic I_REF_OSC,
  input wire logic I_GATE_OSC,
  output logic O_DQ,
  output logic O_DQ_OE,
  output logic O_HIGH_TRIP_OUT,
  output logic O_LOW_TRIP_OUT,
  output logic O_COMBINED_TRIP_OUT
);

  // ==========================================================
  // Pin synchronisers and edge finders
  ttc_pkg::ttc_pins_t pins_async;
  ttc_pkg::ttc_pins_t pins;
  ttc_pkg::ttc_pins_t pins_prev_reg;

  assign pins_async = '{sel: I_PORT_SEL, sclk: I_SHIFT_CLOCK_OR_CONVERT_PIN,
                        dq: I_DQ, ref_osc: I_REF_OSC, gate_osc: I_GATE_OSC};

  ttc_sync u_sync (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_ce(I_CE),
    .i_async(pins_async),
    .o_sync(pins)
  );

  // Previous sample of the synchronised pins for edge detection
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      pins_prev_reg <= '0;
    end else if (I_CE) begin
      pins_prev_reg <= pins;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic ref_rise;
  logic gate_rise;

  assign sclk_rise = I_CE & pins.sclk & ~pins_prev_reg.sclk;
  assign sclk_fall = I_CE & ~pins.sclk & pins_prev_reg.sclk;
  assign ref_rise = I_CE & pins.ref_osc & ~pins_prev_reg.ref_osc;
  assign gate_rise = I_CE & pins.gate_osc & ~pins_prev_reg.gate_osc;

  // ==========================================================
  // Limit storage
  logic mem_we_reg;
  logic mem_we_next;
  logic mem_wsel_reg;
  logic mem_wsel_next;
  logic [8:0] lim_high;
  logic [8:0] lim_low;
  // Serial shift register; the limit store takes its word straight from it
  logic [8:0] sh_reg;

  ttc_lim_mem u_lim (
    .i_clk(I_CORE_CLK),
    .i_ce(I_CE),
    .i_we(mem_we_reg),
    .i_wsel(mem_wsel_reg),
    .i_wdata(sh_reg),
    .o_high(lim_high),
    .o_low(lim_low)
  );

  // ==========================================================
  // Measurement engine
  ttc_pkg::ttc_cv_state_t cv_state_reg;
  ttc_pkg::ttc_cv_state_t cv_state_next;
  logic [8:0] cnt_reg;
  logic [8:0] cnt_next;
  logic [8:0] temp_reg;
  logic [8:0] temp_next;
  logic [8:0] slope_reg;
  logic [8:0] slope_next;
  logic [7:0] gate_cnt_reg;
  logic [7:0] gate_cnt_next;
  logic [27:0] tmo_reg;
  logic [27:0] tmo_next;
  logic [8:0] result_reg;
  logic [8:0] result_next;
  logic [8:0] remain_reg;
  logic [8:0] remain_next;
  logic done_reg;
  logic done_next;
  logic copy_slope_reg;
  logic copy_slope_next;
  logic convert_pin_start;
  logic gate_close;

  localparam logic [27:0] TMO_LAST = 28'(CONVERT_PIN_MAX_CYC - 1);

  // Stand-alone start only while the port is deselected
  assign convert_pin_start = sclk_fall & ~pins.sel & (cv_state_reg == ttc_pkg::CV_IDLE);
  // Gate ends on its own oscillator or at the time limit
  assign gate_close = (gate_rise && (gate_cnt_reg == ttc_pkg::GATE_LEN - ttc_pkg::GATE_ONE))
                    || (tmo_reg == TMO_LAST);

  // Next state of the engine
  always_comb begin
    cv_state_next = cv_state_reg;
    cnt_next = cnt_reg;
    temp_next = temp_reg;
    slope_next = slope_reg;
    gate_cnt_next = gate_cnt_reg;
    tmo_next = tmo_reg;
    result_next = result_reg;
    remain_next = remain_reg;
    done_next = 1'b0;
    if (copy_slope_reg) begin
      remain_next = slope_reg;
    end
    unique case (cv_state_reg)
      ttc_pkg::CV_IDLE: begin
        if (convert_pin_start) begin
          cnt_next = ttc_pkg::BASE_COUNT;
          temp_next = ttc_pkg::TEMP_MIN;
          slope_next = ttc_pkg::SLOPE_BASE;
          gate_cnt_next = '0;
          tmo_next = '0;
          cv_state_next = ttc_pkg::CV_RUN;
        end
      end
      ttc_pkg::CV_RUN: begin
        tmo_next = tmo_reg + ttc_pkg::TMO_ONE;
        if (gate_rise) begin
          gate_cnt_next = gate_cnt_reg + ttc_pkg::GATE_ONE;
        end
        if (ref_rise) begin
          if (cnt_reg <= ttc_pkg::CNT_LAST) begin
            cnt_next = slope_reg;
            slope_next = slope_reg + ttc_pkg::SLOPE_STEP;
            // Saturate so no code beyond the top of the span appears
            if ($signed(temp_reg) < $signed(ttc_pkg::TEMP_MAX)) begin
              temp_next = temp_reg + ttc_pkg::TEMP_STEP;
            end
          end else begin
            cnt_next = cnt_reg - ttc_pkg::CNT_LAST;
          end
        end
        if (gate_close) begin
          result_next = temp_reg;
          remain_next = cnt_reg;
          done_next = 1'b1;
          cv_state_next = ttc_pkg::CV_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      cv_state_reg <= ttc_pkg::CV_IDLE;
      cnt_reg <= ttc_pkg::BASE_COUNT;
      temp_reg <= ttc_pkg::TEMP_MIN;
      slope_reg <= ttc_pkg::SLOPE_BASE;
      gate_cnt_reg <= '0;
      tmo_reg <= '0;
      result_reg <= ttc_pkg::TEMP_MIN;
      remain_reg <= '0;
      done_reg <= 1'b0;
    end else if (I_CE) begin
      cv_state_reg <= cv_state_next;
      cnt_reg <= cnt_next;
      temp_reg <= temp_next;
      slope_reg <= slope_next;
      gate_cnt_reg <= gate_cnt_next;
      tmo_reg <= tmo_next;
      result_reg <= result_next;
      remain_reg <= remain_next;
      done_reg <= done_next;
    end
  end

  // ==========================================================
  // Three-wire serial port
  ttc_pkg::ttc_sp_state_t sp_state_reg;
  ttc_pkg::ttc_sp_state_t sp_state_next;
  logic [3:0] bit_cnt_reg;
  logic [3:0] bit_cnt_next;
  logic [8:0] sh_next;
  logic [8:0] sh_in;
  logic [7:0] opcode;
  logic dq_reg;
  logic dq_next;
  logic oe_reg;
  logic oe_next;

  // New bit enters at the top, so the first bit lands lowest
  assign sh_in = {pins.dq, sh_reg[8:1]};
  assign opcode = sh_in[8:1];

  // Next state of the port; deselect aborts anything in flight
  always_comb begin
    sp_state_next = sp_state_reg;
    bit_cnt_next = bit_cnt_reg;
    sh_next = sh_reg;
    dq_next = dq_reg;
    oe_next = oe_reg;
    mem_we_next = 1'b0;
    mem_wsel_next = mem_wsel_reg;
    copy_slope_next = 1'b0;
    if (!pins.sel) begin
      sp_state_next = ttc_pkg::SP_CMD;
      bit_cnt_next = '0;
      oe_next = 1'b0;
    end else begin
      unique case (sp_state_reg)
        ttc_pkg::SP_CMD: begin
          if (sclk_rise) begin
            sh_next = sh_in;
            bit_cnt_next = bit_cnt_reg + ttc_pkg::BIT_ONE;
            if (bit_cnt_reg == ttc_pkg::CMD_BIT_LAST) begin
              bit_cnt_next = '0;
              sp_state_next = ttc_pkg::SP_OUT;
              unique case (opcode)
                ttc_pkg::OP_RD_TEMP: sh_next = result_reg;
                ttc_pkg::OP_RD_COUNT: sh_next = remain_reg;
                ttc_pkg::OP_RD_SLOPE: begin
                  sh_next = slope_reg;
                  copy_slope_next = 1'b1;
                end
                ttc_pkg::OP_WR_HIGH: begin
                  sp_state_next = ttc_pkg::SP_IN;
                  mem_wsel_next = ttc_pkg::LIM_SEL_HIGH;
                end
                ttc_pkg::OP_WR_LOW: begin
                  sp_state_next = ttc_pkg::SP_IN;
                  mem_wsel_next = ttc_pkg::LIM_SEL_LOW;
                end
                default: sp_state_next = ttc_pkg::SP_DONE;
              endcase
            end
          end
        end
        ttc_pkg::SP_OUT: begin
          // Drive on the falling edge, release while the clock is high
          if (sclk_fall) begin
            dq_next = sh_reg[0];
            sh_next = {1'b0, sh_reg[8:1]};
            oe_next = 1'b1;
          end else if (sclk_rise) begin
            oe_next = 1'b0;
          end
        end
        ttc_pkg::SP_IN: begin
          if (sclk_rise) begin
            sh_next = sh_in;
            bit_cnt_next = bit_cnt_reg + ttc_pkg::BIT_ONE;
            if (bit_cnt_reg == ttc_pkg::DATA_BIT_LAST) begin
              mem_we_next = 1'b1;
              sp_state_next = ttc_pkg::SP_DONE;
            end
          end
        end
        ttc_pkg::SP_DONE: begin
          oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      sp_state_reg <= ttc_pkg::SP_CMD;
      bit_cnt_reg <= '0;
      sh_reg <= '0;
      dq_reg <= 1'b0;
      oe_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_wsel_reg <= ttc_pkg::LIM_SEL_HIGH;
      copy_slope_reg <= 1'b0;
    end else if (I_CE) begin
      sp_state_reg <= sp_state_next;
      bit_cnt_reg <= bit_cnt_next;
      sh_reg <= sh_next;
      dq_reg <= dq_next;
      oe_reg <= oe_next;
      mem_we_reg <= mem_we_next;
      mem_wsel_reg <= mem_wsel_next;
      copy_slope_reg <= copy_slope_next;
    end
  end

  // ==========================================================
  // Thermostat trips; only a finished conversion moves them
  ttc_pkg::ttc_trip_t trip_reg;
  ttc_pkg::ttc_trip_t trip_next;

  always_comb begin
    trip_next = trip_reg;
    if (done_reg) begin
      trip_next.high = $signed(result_reg) >= $signed(lim_high);
      trip_next.low = $signed(result_reg) <= $signed(lim_low);
      if ($signed(result_reg) > $signed(lim_high)) begin
        trip_next.com = 1'b1;
      end else if ($signed(result_reg) < $signed(lim_low)) begin
        trip_next.com = 1'b0;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      trip_reg <= '0;
    end else if (I_CE) begin
      trip_reg <= trip_next;
    end
  end

  assign O_DQ = dq_reg;
  assign O_DQ_OE = oe_reg;
  assign O_HIGH_TRIP_OUT = trip_reg.high;
  assign O_LOW_TRIP_OUT = trip_reg.low;
  assign O_COMBINED_TRIP_OUT = trip_reg.com;

endmodule

`default_nettype wire

// ==== tb/ttc_checker.sv ====
// Checker: port-level assertions for the thermometer/thermostat core
`timescale 1ns/1ps
`default_nettype none
module ttc_checker #(
  parameter int unsigned CONVERT_PIN_MAX_CYC = 8000
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_PORT_SEL,
  input wire logic I_SHIFT_CLOCK_OR_CONVERT_PIN,
  input wire logic O_DQ,
  input wire logic O_DQ_OE,
  input wire logic O_HIGH_TRIP_OUT,
  input wire logic O_LOW_TRIP_OUT,
  input wire logic O_COMBINED_TRIP_OUT
);
  // ==========================================
  // Helper state
  localparam int unsigned LIM = CONVERT_PIN_MAX_CYC + 16;
  logic [31:0] since_reg, since_next;
  logic seen_reg, seen_next, pin_reg, pin_next;
  // Cycles since a convert-pin fall; saturates so it never wraps
  always_comb begin
    since_next = (since_reg == 32'hFFFFFFFF) ? since_reg : since_reg + 32'h1;
    seen_next = seen_reg;
    pin_next = I_SHIFT_CLOCK_OR_CONVERT_PIN;
    if (pin_reg && !I_SHIFT_CLOCK_OR_CONVERT_PIN && !I_PORT_SEL) begin
      since_next = 32'h0;
      seen_next = 1'b1;
    end
    if (I_RST) begin
      since_next = 32'hFFFFFFFF;
      seen_next = 1'b0;
    end
  end
  // Registers only
  always_ff @(posedge I_CORE_CLK) begin
    since_reg <= since_next;
    seen_reg <= seen_next;
    pin_reg <= pin_next;
  end
  // ==========================================
  // Assertions
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  // Sync latency is about 3 cycles, so 6 idle cycles is a safe bound
  sequence s_sel_idle; !I_PORT_SEL [*6]; endsequence
  sequence s_clk_high; I_SHIFT_CLOCK_OR_CONVERT_PIN [*6]; endsequence
  a_sel_abort: assert property (s_sel_idle |-> !O_DQ_OE) else $error("data driven while port idle");
  a_clk_high_off: assert property (s_clk_high |-> !O_DQ_OE) else $error("data driven while clock high");
  a_dq_hold: assert property (O_DQ_OE && $past(O_DQ_OE) |-> $stable(O_DQ)) else $error("data moved");
  a_oe_rise_ok: assert property ($rose(O_DQ_OE) |-> I_PORT_SEL && !I_SHIFT_CLOCK_OR_CONVERT_PIN)
    else $error("data driven outside a low clock phase");
  a_com_rise_high: assert property ($rose(O_COMBINED_TRIP_OUT) |-> O_HIGH_TRIP_OUT)
    else $error("combined trip rose below high limit");
  a_com_fall_low: assert property ($fell(O_COMBINED_TRIP_OUT) |-> O_LOW_TRIP_OUT)
    else $error("combined trip fell above low limit");
  a_rst_quiet: assert property ($fell(I_RST) |-> !(O_HIGH_TRIP_OUT || O_LOW_TRIP_OUT || O_COMBINED_TRIP_OUT || O_DQ_OE))
    else $error("outputs active after reset");
  a_trip_first: assert property (!seen_reg |-> !(O_HIGH_TRIP_OUT || O_LOW_TRIP_OUT || O_COMBINED_TRIP_OUT))
    else $error("trip before first conversion");
  a_trip_window: assert property ($changed({O_HIGH_TRIP_OUT, O_LOW_TRIP_OUT, O_COMBINED_TRIP_OUT}) |-> since_reg <= LIM)
    else $error("trip changed outside a conversion");
endmodule
`default_nettype wire

// ==== tb/ttc_host.sv ====
// Host controller model for the three-wire port and the convert pin
`timescale 1ns/1ps
`default_nettype none
module ttc_host (
  input wire logic i_clk,
  input wire logic i_dq,
  output logic o_sel,
  output logic o_sclk,
  output logic o_dq,
  output logic o_oe
);
  // Shift clock stands high between frames
  initial begin
    o_sel = 1'b0;
    o_sclk = 1'b1;
    o_dq = 1'b0;
    o_oe = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // One clock cycle of 48 ns; read bit taken just before the rise
  task automatic cyc(input logic drv, input logic b, output logic r);
    o_sclk = 1'b0;
    o_oe = drv;
    o_dq = b;
    wt(6);
    r = i_dq;
    o_sclk = 1'b1;
    wt(6);
  endtask
  // One command per select: opcode, then nine bits in or nrd bits out
  task automatic xfer(input logic [7:0] op, input logic [8:0] wd, input int nrd, output logic [17:0] rd);
    logic r;
    rd = 18'h00000;
    o_sel = 1'b1;
    wt(6);
    for (int i = 0; i < 8; i++) cyc(1'b1, op[i], r);
    if (nrd == 0) for (int i = 0; i < 9; i++) cyc(1'b1, wd[i], r);
    for (int i = 0; i < nrd; i++) begin
      cyc(1'b0, 1'b0, r);
      rd[i] = r;
    end
    o_oe = 1'b0;
    o_sel = 1'b0;
    wt(6);
  endtask
  // Stand-alone start: brief low pulse with select low
  task automatic convert_pin_pulse();
    o_sclk = 1'b0;
    wt(4);
    o_sclk = 1'b1;
  endtask
  // Fine temperature scaled by four counts-per-degree, as the host refines it
  function automatic int fine_q(input logic [8:0] t, input logic [8:0] rem, input logic [8:0] cpc);
    return (4 * int'($signed(t) >>> 1) - 1) * int'(cpc) + 4 * (int'(cpc) - int'(rem));
  endfunction
endmodule
`default_nettype wire

// ==== tb/tb_thermometer_thermostat_core.sv ====
// Testbench: host model, oscillators and checks for the thermometer/thermostat core
`timescale 1ns/1ps
`default_nettype none
module tb_thermometer_thermostat_core;
  localparam int unsigned CMAX = 8000;
  logic clk, rst, ce, ref_osc, gate_osc, dq_last, h_sel, h_sclk, h_dq, h_oe, o_dq, o_oe, t_hi, t_lo, combined_trip_out;
  wire logic dq_wire;
  int miscompares, comparisons, cycles, n;
  int corner[5] = '{0, 199, 200, 263, 264};
  logic [8:0] e_temp, e_cnt, e_slope, hi, lo, r_temp, r_cnt;
  logic e_com;
  logic [17:0] rd;
  ttc_core #(.CONVERT_PIN_MAX_CYC(CMAX)) dut (.I_CORE_CLK(clk), .I_RST(rst), .I_CE(ce), .I_PORT_SEL(h_sel),
    .I_SHIFT_CLOCK_OR_CONVERT_PIN(h_sclk), .I_DQ(dq_wire), .I_REF_OSC(ref_osc), .I_GATE_OSC(gate_osc),
    .O_DQ(o_dq), .O_DQ_OE(o_oe), .O_HIGH_TRIP_OUT(t_hi), .O_LOW_TRIP_OUT(t_lo), .O_COMBINED_TRIP_OUT(combined_trip_out));
  ttc_host host (.i_clk(clk), .i_dq(dq_wire), .o_sel(h_sel), .o_sclk(h_sclk), .o_dq(h_dq), .o_oe(h_oe));
  // Released line shows the inverse of its last level, never a kind guess
  assign dq_wire = o_oe ? o_dq : (h_oe ? h_dq : ~dq_last);
  always @(posedge clk) if (o_oe || h_oe) dq_last <= dq_wire;
  // ==========================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Engine model over n reference edges that all land inside the gate
  function automatic void model(input int n);
    logic [8:0] c;
    e_temp = ttc_pkg::TEMP_MIN;
    c = ttc_pkg::BASE_COUNT;
    e_slope = ttc_pkg::SLOPE_BASE;
    for (int k = 0; k < n; k++) begin
      if (c <= ttc_pkg::CNT_LAST) begin
        if (e_temp != ttc_pkg::TEMP_MAX) e_temp = e_temp + ttc_pkg::TEMP_STEP;
        c = e_slope;
        e_slope = e_slope + ttc_pkg::SLOPE_STEP;
      end else c = c - 9'h001;
    end
    e_cnt = c;
  endfunction
  // Reference edges first, gate after, so every count is inside the gate
  task automatic convert(input int nref, input logic gated);
    host.convert_pin_pulse();
    repeat (8) @(negedge clk);
    repeat (nref) begin
      ref_osc = 1'b1;
      repeat (4) @(negedge clk);
      ref_osc = 1'b0;
      repeat (4) @(negedge clk);
    end
    if (gated) repeat (ttc_pkg::GATE_LEN) begin
      gate_osc = 1'b1;
      repeat (4) @(negedge clk);
      gate_osc = 1'b0;
      repeat (4) @(negedge clk);
    end else repeat (CMAX) @(negedge clk);
    repeat (12) @(negedge clk);
  endtask
  // Trip levels with hysteresis on the combined output
  task automatic check_trips();
    if ($signed(e_temp) > $signed(hi)) e_com = 1'b1;
    else if ($signed(e_temp) < $signed(lo)) e_com = 1'b0;
    check("high_trip", 18'(t_hi), 18'($signed(e_temp) >= $signed(hi)));
    check("low_trip", 18'(t_lo), 18'($signed(e_temp) <= $signed(lo)));
    check("combined_trip", 18'(combined_trip_out), 18'(e_com));
  endtask
  // ==========================================
  // Main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    ref_osc = 1'b0;
    gate_osc = 1'b0;
    dq_last = 1'b0;
    miscompares = 0;
    comparisons = 0;
    cycles = 0;
    e_com = 1'b0;
    hi = ttc_pkg::LIM_HIGH_INIT;
    lo = ttc_pkg::LIM_LOW_INIT;
    void'($urandom(32'h5F8A));
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check("trips_idle", 18'({t_hi, t_lo, combined_trip_out}), 18'h00000);
    for (int i = 0; i < 8; i++) begin
      n = (i < 5) ? corner[i] : int'($urandom_range(400, 0));
      model(n);
      if (i == 4) begin
        // Mid-run reset: limits must survive it
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        e_com = 1'b0;
        repeat (4) @(negedge clk);
        check("trips_reset", 18'({t_hi, t_lo, combined_trip_out}), 18'h00000);
      end else begin
        hi = e_temp + 9'($urandom_range(4, 0)) - 9'h002;
        lo = e_temp + 9'($urandom_range(4, 0)) - 9'h002;
        host.xfer(ttc_pkg::OP_WR_HIGH, hi, 0, rd);
        host.xfer(ttc_pkg::OP_WR_LOW, lo, 0, rd);
        // A frozen core or an unknown opcode must leave the high limit alone
        if (i == 2 || i == 6) begin
          ce = (i == 6);
          host.xfer((i == 2) ? ttc_pkg::OP_WR_HIGH : 8'h81,
            ($signed(e_temp) >= $signed(hi)) ? 9'h0FF : 9'h100, 0, rd);
          ce = 1'b1;
        end
      end
      convert(n, i != 7);
      check_trips();
      host.xfer(ttc_pkg::OP_RD_TEMP, 9'h000, 18, rd);
      check("temp", rd, {9'h000, e_temp});
      r_temp = rd[8:0];
      host.xfer(ttc_pkg::OP_RD_COUNT, 9'h000, 9, rd);
      check("count", rd, 18'(e_cnt));
      r_cnt = rd[8:0];
      host.xfer(ttc_pkg::OP_RD_SLOPE, 9'h000, 9, rd);
      check("slope", rd, 18'(e_slope));
      check("fine", 18'(host.fine_q(r_temp, r_cnt, rd[8:0])), 18'(host.fine_q(e_temp, e_cnt, e_slope)));
      host.xfer(ttc_pkg::OP_RD_COUNT, 9'h000, 9, rd);
      check("count_after_slope", rd, 18'(e_slope));
      $display("test %0d done, %0d reference edges", i, n);
    end
    summarize();
  end
endmodule
bind ttc_core ttc_checker #(.CONVERT_PIN_MAX_CYC(CONVERT_PIN_MAX_CYC)) u_chk (.I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST),
  .I_PORT_SEL(I_PORT_SEL), .I_SHIFT_CLOCK_OR_CONVERT_PIN(I_SHIFT_CLOCK_OR_CONVERT_PIN), .O_DQ(O_DQ),
  .O_DQ_OE(O_DQ_OE), .O_HIGH_TRIP_OUT(O_HIGH_TRIP_OUT), .O_LOW_TRIP_OUT(O_LOW_TRIP_OUT),
  .O_COMBINED_TRIP_OUT(O_COMBINED_TRIP_OUT));
`default_nettype wire
